/* File: verilog/spd_pointer_regs.sv */
`timescale 1ns/100ps
`include "spd_params.svh"
`default_nettype none
// Summary of operation
// - the stack pointer answers at special address 0x81, has no bit access, and resets to 0x07.
// - after any reset the stack pointer is 0x07 so the first push lands at 0x08.
// - a call saves the program counter low then high byte into stack memory at the pointer.
// - a return restores the program counter high then low byte from the stack at the pointer.
// - push stores a byte at the pointer location and pop fetches the byte there.
// - each stack write pre-increments the pointer and each read post-decrements it.
// - the data pointer is reached as low byte at 0x82 and high byte at 0x83.
// - the data pointer has no bit access and clears to 0x0000 on reset.
// - external data moves use the full 16-bit data pointer as address.
// - code byte move reads program memory at accumulator plus data pointer into the accumulator.
// - indirect jump loads the program counter with accumulator plus data pointer.
// - the data pointer supports 16-bit immediate load and increment with carry.
module spd_pointer_regs (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic op_valid,
    input wire spd_pkg::spd_op_t op_code,
    input wire logic [15:0] op_data,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] acc_in,
    output logic op_ready,
    output logic op_done,
    output logic [15:0] result_data,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    output logic [15:0] ext_addr,
    output logic [15:0] code_addr,
    output logic code_rd,
    input wire logic [7:0] code_data,
    input wire logic code_valid,
    output logic [7:0] stack_top_pointer,
    output logic [15:0] data_pointer_pair
);
    typedef struct packed {
        spd_pkg::spd_state_t st;
        spd_pkg::spd_op_t op;
        logic [7:0] sp;
        logic [15:0] dp;
        logic [7:0] lo_byte;
        logic done;
        logic [15:0] result;
        logic [7:0] rdata;
        logic [15:0] code_addr;
        logic code_rd;
    } spd_state_s_t;

    spd_state_s_t state_ff;
    spd_state_s_t nxt_state;
    logic ram_we;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;

    function automatic logic [15:0] spd_sum(input logic [7:0] a, input logic [15:0] d);
        spd_sum = d + {`SPD_ZERO8, a};
    endfunction : spd_sum

    spd_stack_ram #(.ADDR_W(8)) u_ram (
        .ref_clk(ref_clk),
        .wr_en(ram_we),
        .addr(ram_addr),
        .wr_data(ram_wdata),
        .rd_data(ram_rdata)
    );

    // stack port decoded combinationally; pops read at sp so ram data is ready next cycle
    always_comb begin
        ram_we = 1'b0;
        ram_addr = state_ff.sp;
        ram_wdata = sfr_wdata;
        if (state_ff.st == spd_pkg::SPD_ST_IDLE && op_valid) begin
            case (op_code)
                spd_pkg::SPD_OP_PUSH: begin
                    ram_we = 1'b1;
                    ram_addr = state_ff.sp + `SPD_ONE8;
                    ram_wdata = op_data[7:0];
                end
                spd_pkg::SPD_OP_CALL: begin
                    ram_we = 1'b1;
                    ram_addr = state_ff.sp + `SPD_ONE8;
                    ram_wdata = pc_in[7:0];
                end
                default: begin
                    ram_addr = state_ff.sp;
                end
            endcase
        end else if (state_ff.st == spd_pkg::SPD_ST_SECOND && state_ff.op == spd_pkg::SPD_OP_CALL) begin
            ram_we = 1'b1;
            ram_addr = state_ff.sp + `SPD_ONE8;
            ram_wdata = state_ff.lo_byte;
        end else begin
            ram_addr = state_ff.sp;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.done = 1'b0;
        nxt_state.code_rd = 1'b0;
        case (state_ff.st)
            spd_pkg::SPD_ST_IDLE: begin
                if (op_valid) begin
                    nxt_state.op = op_code;
                    case (op_code)
                        spd_pkg::SPD_OP_PUSH: begin
                            nxt_state.sp = state_ff.sp + `SPD_ONE8;
                            nxt_state.done = 1'b1;
                        end
                        spd_pkg::SPD_OP_CALL: begin
                            nxt_state.sp = state_ff.sp + `SPD_ONE8;
                            nxt_state.lo_byte = pc_in[15:8];
                            nxt_state.st = spd_pkg::SPD_ST_SECOND;
                        end
                        spd_pkg::SPD_OP_POP, spd_pkg::SPD_OP_RET: begin
                            nxt_state.sp = state_ff.sp - `SPD_ONE8;
                            nxt_state.st = spd_pkg::SPD_ST_SECOND;
                        end
                        spd_pkg::SPD_OP_DP_LOAD: begin
                            nxt_state.dp = op_data;
                            nxt_state.done = 1'b1;
                        end
                        spd_pkg::SPD_OP_DP_INC: begin
                            nxt_state.dp = state_ff.dp + `SPD_ONE16;
                            nxt_state.done = 1'b1;
                        end
                        spd_pkg::SPD_OP_JUMP: begin
                            nxt_state.result = spd_sum(acc_in, state_ff.dp);
                            nxt_state.done = 1'b1;
                        end
                        spd_pkg::SPD_OP_CODE_MOVE: begin
                            nxt_state.code_addr = spd_sum(acc_in, state_ff.dp);
                            nxt_state.code_rd = 1'b1;
                            nxt_state.st = spd_pkg::SPD_ST_FETCH;
                        end
                        spd_pkg::SPD_OP_XMOVE: begin
                            nxt_state.result = state_ff.dp;
                            nxt_state.done = 1'b1;
                        end
                        default: begin
                            nxt_state.done = 1'b0;
                        end
                    endcase
                end else if (sfr_wr) begin
                    case (sfr_addr)
                        `SPD_ADDR_STACK: nxt_state.sp = sfr_wdata;
                        `SPD_ADDR_DPL: nxt_state.dp[7:0] = sfr_wdata;
                        `SPD_ADDR_DPH: nxt_state.dp[15:8] = sfr_wdata;
                        default: nxt_state.sp = state_ff.sp;
                    endcase
                end
                // read data moves only on a read strobe, so it holds for a slow reader
                if (sfr_rd) begin
                    case (sfr_addr)
                        `SPD_ADDR_STACK: nxt_state.rdata = state_ff.sp;
                        `SPD_ADDR_DPL: nxt_state.rdata = state_ff.dp[7:0];
                        `SPD_ADDR_DPH: nxt_state.rdata = state_ff.dp[15:8];
                        default: nxt_state.rdata = `SPD_ZERO8;
                    endcase
                end
            end
            spd_pkg::SPD_ST_SECOND: begin
                if (state_ff.op == spd_pkg::SPD_OP_CALL) begin
                    nxt_state.sp = state_ff.sp + `SPD_ONE8;
                    nxt_state.done = 1'b1;
                    nxt_state.st = spd_pkg::SPD_ST_IDLE;
                end else if (state_ff.op == spd_pkg::SPD_OP_POP) begin
                    nxt_state.result = {`SPD_ZERO8, ram_rdata};
                    nxt_state.done = 1'b1;
                    nxt_state.st = spd_pkg::SPD_ST_IDLE;
                end else if (state_ff.op == spd_pkg::SPD_OP_RET) begin
                    // return: first read gave high byte, now read low byte
                    nxt_state.lo_byte = ram_rdata;
                    nxt_state.sp = state_ff.sp - `SPD_ONE8;
                    nxt_state.op = spd_pkg::SPD_OP_NONE;
                end
            end
            spd_pkg::SPD_ST_FETCH: begin
                if (code_valid) begin
                    nxt_state.result = {`SPD_ZERO8, code_data};
                    nxt_state.done = 1'b1;
                    nxt_state.st = spd_pkg::SPD_ST_IDLE;
                end
            end
            default: nxt_state.st = spd_pkg::SPD_ST_IDLE;
        endcase
        // return finishes one cycle after the high byte was latched
        if (state_ff.st == spd_pkg::SPD_ST_SECOND && state_ff.op == spd_pkg::SPD_OP_NONE) begin
            nxt_state.result = {state_ff.lo_byte, ram_rdata};
            nxt_state.done = 1'b1;
            nxt_state.st = spd_pkg::SPD_ST_IDLE;
        end
        if (reset) begin
            nxt_state = '0;
            nxt_state.sp = `SPD_SP_RESET;
            nxt_state.dp = `SPD_DP_RESET;
            nxt_state.st = spd_pkg::SPD_ST_IDLE;
            nxt_state.op = spd_pkg::SPD_OP_NONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        state_ff <= nxt_state;
    end

    assign op_ready = (state_ff.st == spd_pkg::SPD_ST_IDLE);
    assign op_done = state_ff.done;
    assign result_data = state_ff.result;
    assign sfr_rdata = state_ff.rdata;
    assign sfr_hit = (sfr_addr == `SPD_ADDR_STACK) || (sfr_addr == `SPD_ADDR_DPL)
        || (sfr_addr == `SPD_ADDR_DPH);
    assign ext_addr = state_ff.dp;
    assign code_addr = state_ff.code_addr;
    assign code_rd = state_ff.code_rd;
    assign stack_top_pointer = state_ff.sp;
    assign data_pointer_pair = state_ff.dp;

    a_sp_reset_val: assert property (@(posedge ref_clk) reset |=> stack_top_pointer == `SPD_SP_RESET)
        else $error("stack pointer not 0x07 after reset");
    a_dp_reset_val: assert property (@(posedge ref_clk) reset |=> data_pointer_pair == `SPD_DP_RESET)
        else $error("data pointer not cleared by reset");
    a_push_inc_sp: assert property (@(posedge ref_clk) disable iff (reset)
        (op_valid && op_ready && op_code == spd_pkg::SPD_OP_PUSH)
        |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01 && op_done)
        else $error("push did not advance stack pointer");
    a_call_two_bytes: assert property (@(posedge ref_clk) disable iff (reset)
        (op_valid && op_ready && op_code == spd_pkg::SPD_OP_CALL)
        |=> ##1 stack_top_pointer == $past(stack_top_pointer, 2) + 8'h02 && op_done)
        else $error("call did not push two bytes");
    a_ret_two_bytes: assert property (@(posedge ref_clk) disable iff (reset)
        (op_valid && op_ready && op_code == spd_pkg::SPD_OP_RET)
        |=> ##2 stack_top_pointer == $past(stack_top_pointer, 3) - 8'h02 && op_done)
        else $error("return did not pop two bytes");
    a_pop_dec_sp: assert property (@(posedge ref_clk) disable iff (reset)
        (op_valid && op_ready && op_code == spd_pkg::SPD_OP_POP)
        |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01 ##1 op_done)
        else $error("pop did not retreat stack pointer");
    a_dp_inc_carry: assert property (@(posedge ref_clk) disable iff (reset)
        (op_valid && op_ready && op_code == spd_pkg::SPD_OP_DP_INC)
        |=> data_pointer_pair == $past(data_pointer_pair) + 16'h0001)
        else $error("data pointer increment wrong");
    a_jump_target: assert property (@(posedge ref_clk) disable iff (reset)
        (op_valid && op_ready && op_code == spd_pkg::SPD_OP_JUMP)
        |=> result_data == $past(data_pointer_pair) + {8'h00, $past(acc_in)})
        else $error("indirect jump target wrong");
    a_dph_write: assert property (@(posedge ref_clk) disable iff (reset)
        (!op_valid && op_ready && sfr_wr && sfr_addr == `SPD_ADDR_DPH)
        |=> data_pointer_pair[15:8] == $past(sfr_wdata))
        else $error("high data pointer byte write lost");
endmodule : spd_pointer_regs
`default_nettype wire

/* File: verilog/spd_params.svh */
`ifndef SPD_PARAMS_SVH
`define SPD_PARAMS_SVH
`define SPD_ADDR_STACK 8'h81
`define SPD_ADDR_DPL 8'h82
`define SPD_ADDR_DPH 8'h83
`define SPD_SP_RESET 8'h07
`define SPD_DP_RESET 16'h0000
`define SPD_ONE8 8'h01
`define SPD_ONE16 16'h0001
`define SPD_ZERO8 8'h00
`endif

/* File: verilog/spd_pkg.sv */
`default_nettype none
package spd_pkg;
    typedef enum logic [3:0] {
        SPD_OP_NONE = 4'b0000,
        SPD_OP_PUSH = 4'b0001,
        SPD_OP_POP = 4'b0010,
        SPD_OP_CALL = 4'b0011,
        SPD_OP_RET = 4'b0100,
        SPD_OP_DP_LOAD = 4'b0101,
        SPD_OP_DP_INC = 4'b0110,
        SPD_OP_XMOVE = 4'b0111,
        SPD_OP_CODE_MOVE = 4'b1000,
        SPD_OP_JUMP = 4'b1001
    } spd_op_t;
    typedef enum logic [1:0] {
        SPD_ST_IDLE = 2'b00,
        SPD_ST_SECOND = 2'b01,
        SPD_ST_FETCH = 2'b10
    } spd_state_t;
endpackage : spd_pkg
`default_nettype wire

/* File: verilog/spd_stack_ram.sv */
`timescale 1ns/100ps
`default_nettype none
module spd_stack_ram #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    // registered read: data valid the cycle after addr
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule : spd_stack_ram
`default_nettype wire

/* File: tb/spd_code_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module spd_code_mem (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic code_rd,
    input wire logic [15:0] code_addr,
    input wire logic [3:0] wait_cycles,
    output logic [7:0] code_data,
    output logic code_valid
);
    logic [15:0] addr_ff;
    logic [3:0] cnt_ff;
    logic busy_ff;
    logic [7:0] last_ff;
    // between answers the data bus toggles, so a late sample sees the last byte and its inverse on alternate cycles
    always_ff @(posedge ref_clk) begin
        code_valid <= 1'b0;
        code_data <= ~code_data;
        if (reset) begin
            busy_ff <= 1'b0;
            last_ff <= 8'h00;
            code_data <= 8'hff;
        end else if (code_rd) begin
            addr_ff <= code_addr;
            cnt_ff <= wait_cycles;
            busy_ff <= 1'b1;
            code_data <= ~last_ff;
        end else if (busy_ff && cnt_ff == 4'h0) begin
            code_valid <= 1'b1;
            code_data <= addr_ff[7:0] ^ addr_ff[15:8] ^ 8'h5a;
            last_ff <= addr_ff[7:0] ^ addr_ff[15:8] ^ 8'h5a;
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
endmodule : spd_code_mem
`default_nettype wire

/* File: tb/stack_and_data_pointer_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module stack_and_data_pointer_regs_tb;
    logic ref_clk, reset, op_valid, op_ready, op_done, sfr_wr, sfr_rd, sfr_hit, code_rd, code_valid;
    spd_pkg::spd_op_t op_code;
    logic [15:0] op_data, pc_in, result_data, ext_addr, code_addr, data_pointer_pair, dp_m, d;
    logic [7:0] acc_in, sfr_addr, sfr_wdata, sfr_rdata, code_data, stack_top_pointer, sp_m, e;
    logic [3:0] wait_cycles;
    logic [7:0] stk[$];
    int num_errors, n_compared, seed, k, i;
    spd_pointer_regs spd_pointer_regs_inst (.ref_clk(ref_clk), .reset(reset),
        .op_valid(op_valid), .op_code(op_code), .op_data(op_data), .pc_in(pc_in),
        .acc_in(acc_in), .op_ready(op_ready), .op_done(op_done), .result_data(result_data),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .ext_addr(ext_addr), .code_addr(code_addr),
        .code_rd(code_rd), .code_data(code_data), .code_valid(code_valid),
        .stack_top_pointer(stack_top_pointer), .data_pointer_pair(data_pointer_pair));
    spd_code_mem spd_code_mem_inst (.ref_clk(ref_clk), .reset(reset), .code_rd(code_rd),
        .code_addr(code_addr), .wait_cycles(wait_cycles), .code_data(code_data),
        .code_valid(code_valid));
    function automatic logic [7:0] code_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : code_byte
    function automatic logic sfr_mapped(input logic [7:0] a);
        return (a == 8'h81) || (a == 8'h82) || (a == 8'h83);
    endfunction : sfr_mapped
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    task automatic do_op(input spd_pkg::spd_op_t c, input logic [15:0] v);
        op_code = c;
        op_data = v;
        op_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        op_valid = 1'b0;
        for (int j = 0; j < 20 && op_done !== 1'b1; j++) begin
            @(posedge ref_clk);
            #1;
        end
        check({15'h0000, op_done}, 16'h0001);
        check({15'h0000, op_ready}, 16'h0001);
        // let an edge pass so the next request never re-raises valid in this time step
        @(posedge ref_clk);
        #1;
    endtask : do_op
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        check({8'h00, sfr_rdata}, {8'h00, exp});
        check({15'h0000, sfr_hit}, {15'h0000, sfr_mapped(a)});
        sfr_rd = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : sfr_read
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_wr = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : sfr_write
    task automatic chk_regs();
        check({8'h00, stack_top_pointer}, {8'h00, sp_m});
        check(data_pointer_pair, dp_m);
        sfr_read(8'h81, sp_m);
        sfr_read(8'h82, dp_m[7:0]);
        sfr_read(8'h83, dp_m[15:8]);
    endtask : chk_regs
    task automatic do_reset();
        reset = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        sp_m = 8'h07;
        dp_m = 16'h0000;
        stk.delete();
        chk_regs();
    endtask : do_reset
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #(5 * 6000);
        num_errors++;
        conclude();
    end
    initial begin
        seed = 32'h0105;
        {op_valid, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, acc_in, wait_cycles} = '0;
        op_code = spd_pkg::SPD_OP_NONE;
        op_data = 16'h0000;
        pc_in = 16'h0000;
        do_reset();
        sfr_read(8'h90, 8'h00);
        for (i = 0; i < 60; i++) begin
            k = $unsigned($random(seed)) % 4;
            d = 16'($random(seed));
            if (k == 0 || stk.size() < 2) begin
                do_op(spd_pkg::SPD_OP_PUSH, {8'h00, d[7:0]});
                stk.push_back(d[7:0]);
                sp_m++;
            end else if (k == 1) begin
                do_op(spd_pkg::SPD_OP_POP, 16'h0000);
                check({8'h00, result_data[7:0]}, {8'h00, stk.pop_back()});
                sp_m--;
            end else if (k == 2) begin
                pc_in = d;
                do_op(spd_pkg::SPD_OP_CALL, 16'h0000);
                stk.push_back(d[7:0]);
                stk.push_back(d[15:8]);
                sp_m = sp_m + 8'h02;
            end else begin
                e = stk.pop_back();
                do_op(spd_pkg::SPD_OP_RET, 16'h0000);
                check(result_data, {e, stk.pop_back()});
                sp_m = sp_m - 8'h02;
            end
            check({8'h00, stack_top_pointer}, {8'h00, sp_m});
        end
        chk_regs();
        sfr_write(8'h81, 8'hff);
        sp_m = 8'hff;
        do_op(spd_pkg::SPD_OP_PUSH, 16'h00a5);
        check({8'h00, stack_top_pointer}, 16'h0000);
        do_op(spd_pkg::SPD_OP_POP, 16'h0000);
        check({8'h00, result_data[7:0]}, 16'h00a5);
        chk_regs();
        sfr_write(8'h82, 8'hff);
        sfr_write(8'h83, 8'h12);
        dp_m = 16'h12ff;
        chk_regs();
        for (i = 0; i < 8; i++) begin
            if (i > 0) begin
                dp_m = 16'($random(seed));
                do_op(spd_pkg::SPD_OP_DP_LOAD, dp_m);
            end
            do_op(spd_pkg::SPD_OP_DP_INC, 16'h0000);
            dp_m++;
            check(data_pointer_pair, dp_m);
            do_op(spd_pkg::SPD_OP_XMOVE, 16'h0000);
            check(ext_addr, dp_m);
            check(result_data, dp_m);
            acc_in = 8'($random(seed));
            wait_cycles = (i == 1) ? 4'hf : 4'($unsigned($random(seed)) % 8);
            do_op(spd_pkg::SPD_OP_CODE_MOVE, 16'h0000);
            check(code_addr, dp_m + {8'h00, acc_in});
            check({8'h00, result_data[7:0]}, {8'h00, code_byte(dp_m + {8'h00, acc_in})});
            do_op(spd_pkg::SPD_OP_JUMP, 16'h0000);
            check(result_data, dp_m + {8'h00, acc_in});
        end
        chk_regs();
        do_reset();
        conclude();
    end
endmodule : stack_and_data_pointer_regs_tb
`default_nettype wire
